// file: src/charger_ctrl.sv
// source selection, charge phase sequencing, thermal loop and usb reduction
// assumes comparator and pin inputs asynchronous to sys_clk, AXI4-Lite master
// How it works
// - adapter beats usb whenever adapter present
// - presence pin pulled low while adapter detected
// - thermal entry drops current to 0.44
// - every three seconds step current back up
// - adapter undervoltage suspends and sleeps
// - adapter recovery reassesses then resumes
// - no adapter means charge from usb
// - select high picks high level, floats low
// - usb levels 50..500mA, adapter to 1.5A
// - usb sag ramps usb current down
// - reduction same for both usb levels
// - usb undervoltage suspends and sleeps
// - usb recovery reassesses then resumes
// - enable low forces sleep, stops charging
// - re-enable resets and reassesses battery
// - precondition, fast, voltage, done sequence
// - precondition is tenth, half on usb low
// - terminate at 7.5% or 35%, recharge
module charger_ctrl #(
  parameter int THERM_CYC = charger_pkg::THERM_CYC,
  parameter int REDUCE_CYC = charger_pkg::REDUCE_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic adapter_supply_input,
  input wire logic adp_above_undervoltage_lockout,
  input wire logic adp_above_bat,
  input wire logic usb_above_undervoltage_lockout,
  input wire logic reduction_threshold_input,
  input wire logic usb_level_select,
  input wire logic enable,
  input wire logic die_hot,
  input wire logic bat_above_min,
  input wire logic bat_at_reg,
  input wire logic bat_below_rch,
  input wire logic cur_below_term,
  output logic adapter_present_n_out,
  output logic adapter_present_n_oe_n,
  output logic src_adp,
  output logic src_usb,
  output logic usb_high_current_level,
  output charger_pkg::phase_t phase,
  output logic [9:0] charge_permille,
  output logic [9:0] term_permille,
  output logic [10:0] fast_charge_current,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // pin synchronisers
  logic [11:0] pins_meta_q, pins_q;
  always_ff @(posedge sys_clk) begin
    pins_meta_q <= {cur_below_term, bat_below_rch, bat_at_reg, bat_above_min,
                    die_hot, enable, usb_level_select, reduction_threshold_input,
                    usb_above_undervoltage_lockout, adp_above_bat, adp_above_undervoltage_lockout,
                    adapter_supply_input};
    pins_q <= pins_meta_q;
  end
  wire adp_det = pins_q[0];
  wire adp_ok = pins_q[0] & pins_q[1] & pins_q[2];
  wire usb_ok = pins_q[3];
  wire usb_sag = pins_q[4];
  wire sel_high = pins_q[5];
  wire en_s = pins_q[6];
  wire hot = pins_q[7];
  wire bat_min = pins_q[8];
  wire bat_reg = pins_q[9];
  wire bat_rch = pins_q[10];
  wire cur_term = pins_q[11];
  wire use_adp = adp_ok;
  wire use_usb = ~adp_det & usb_ok;
  wire src_ok = en_s & (use_adp | use_usb);

  // register file
  logic [10:0] adp_ma_q, usb_high_current_level_ma_q, usb_low_current_level_ma_q;
  logic [3:0] evt_stat_q, evt_en_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic aw_full_q, w_full_q;
  wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_full_strb = &s_axi_wstrb;
  wire [10:0] wr_ma = wdata_q[10:0];
  wire wr_big = |wdata_q[31:11];
  // clamp programmed levels into their legal ranges
  wire [10:0] adp_ma_clamp = (wr_big || wr_ma > charger_pkg::MA_ADP_MAX) ?
      charger_pkg::MA_ADP_MAX : wr_ma;
  wire [10:0] usb_ma_clamp = (wr_big || wr_ma > charger_pkg::MA_USB_MAX) ?
      charger_pkg::MA_USB_MAX : (wr_ma < charger_pkg::MA_USB_MIN) ?
      charger_pkg::MA_USB_MIN : wr_ma;
  wire wr_adp = do_wr && awaddr_q == charger_pkg::ADP_LEVEL_OFS;
  wire wr_usb_high_current_level = do_wr && awaddr_q == charger_pkg::USB_HIGH_CURRENT_LEVEL_LEVEL_OFS;
  wire wr_usb_low_current_level = do_wr && awaddr_q == charger_pkg::USB_LOW_CURRENT_LEVEL_LEVEL_OFS;
  wire wr_clr = do_wr && awaddr_q == charger_pkg::EVT_CLR_OFS;
  wire wr_en = do_wr && awaddr_q == charger_pkg::EVT_EN_OFS;
  wire wr_hit = wr_adp | wr_usb_high_current_level | wr_usb_low_current_level | wr_clr | wr_en;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= charger_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? charger_pkg::RESP_OKAY :
                       charger_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_full_q & ~sys_rst;
  assign s_axi_wready = ~w_full_q & ~sys_rst;

  // partial-strobe writes to level registers are ignored, not merged
  logic wr_strb_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) wr_strb_q <= 1'b0;
    else if (w_take) wr_strb_q <= wr_full_strb;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      adp_ma_q <= charger_pkg::ADP_MA_RST;
      usb_high_current_level_ma_q <= charger_pkg::USB_HIGH_CURRENT_LEVEL_MA_RST;
      usb_low_current_level_ma_q <= charger_pkg::USB_LOW_CURRENT_LEVEL_MA_RST;
      evt_en_q <= 4'h0;
    end else begin
      if (wr_adp && wr_strb_q) adp_ma_q <= adp_ma_clamp;
      if (wr_usb_high_current_level && wr_strb_q) usb_high_current_level_ma_q <= usb_ma_clamp;
      if (wr_usb_low_current_level && wr_strb_q) usb_low_current_level_ma_q <= usb_ma_clamp;
      if (wr_en) evt_en_q <= wdata_q[3:0];
    end
  end

  // charge phase sequencing
  charger_pkg::phase_t phase_q, phase_d;
  logic src_adp_q, src_usb_q;
  wire src_change = (use_adp != src_adp_q) | (use_usb != src_usb_q);
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      charger_pkg::PH_SLEEP: if (src_ok) phase_d = charger_pkg::PH_ASSESS;
      charger_pkg::PH_ASSESS:
        phase_d = !bat_min ? charger_pkg::PH_PRECON :
                  bat_reg ? charger_pkg::PH_CV : charger_pkg::PH_FAST;
      charger_pkg::PH_PRECON: if (bat_min) phase_d = charger_pkg::PH_FAST;
      charger_pkg::PH_FAST: if (bat_reg) phase_d = charger_pkg::PH_CV;
      charger_pkg::PH_CV: if (cur_term) phase_d = charger_pkg::PH_DONE;
      charger_pkg::PH_DONE: if (bat_rch) phase_d = charger_pkg::PH_ASSESS;
      default: phase_d = charger_pkg::PH_SLEEP;
    endcase
    // any lost supply or enable wins over the sequence
    if (!src_ok) phase_d = charger_pkg::PH_SLEEP;
    else if (src_change && phase_q != charger_pkg::PH_SLEEP)
      phase_d = charger_pkg::PH_ASSESS;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_q <= charger_pkg::PH_SLEEP;
      src_adp_q <= 1'b0;
      src_usb_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      src_adp_q <= use_adp;
      src_usb_q <= use_usb;
    end
  end
  wire charging = phase_q == charger_pkg::PH_PRECON ||
                  phase_q == charger_pkg::PH_FAST ||
                  phase_q == charger_pkg::PH_CV;

  // thermal loop, adapter charging only
  logic therm_q;
  logic [9:0] therm_pm_q;
  logic [charger_pkg::TIMER_W-1:0] therm_cnt_q;
  wire therm_tick = therm_cnt_q == charger_pkg::TIMER_W'(THERM_CYC - 1);
  wire therm_enter = ~therm_q & hot & src_adp_q & charging;
  wire [9:0] therm_up = therm_pm_q + charger_pkg::PM_THERM_STEP;
  wire therm_top = therm_up >= charger_pkg::PM_FULL;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !src_adp_q || !charging) begin
      therm_q <= 1'b0;
      therm_pm_q <= charger_pkg::PM_FULL;
      therm_cnt_q <= '0;
    end else if (therm_enter) begin
      therm_q <= 1'b1;
      therm_pm_q <= charger_pkg::PM_THERM_START;
      therm_cnt_q <= '0;
    end else if (therm_q) begin
      therm_cnt_q <= therm_tick ? '0 : therm_cnt_q + 1'b1;
      // still hot: hold the level found, it is the equilibrium
      if (therm_tick && !hot) begin
        therm_pm_q <= therm_top ? charger_pkg::PM_FULL : therm_up;
        therm_q <= ~therm_top;
      end
    end
  end

  // usb charge reduction, same limit for both levels
  logic [9:0] usb_pm_q;
  logic [charger_pkg::TIMER_W-1:0] red_cnt_q;
  wire red_tick = red_cnt_q == charger_pkg::TIMER_W'(REDUCE_CYC - 1);
  wire red_low = usb_pm_q <= charger_pkg::PM_REDUCE_MIN +
                 charger_pkg::PM_REDUCE_STEP;
  wire red_high = usb_pm_q >= charger_pkg::PM_FULL -
                  charger_pkg::PM_REDUCE_STEP;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !src_usb_q) begin
      usb_pm_q <= charger_pkg::PM_FULL;
      red_cnt_q <= '0;
    end else begin
      red_cnt_q <= red_tick ? '0 : red_cnt_q + 1'b1;
      if (red_tick && usb_sag)
        usb_pm_q <= red_low ? charger_pkg::PM_REDUCE_MIN :
                    usb_pm_q - charger_pkg::PM_REDUCE_STEP;
      else if (red_tick)
        usb_pm_q <= red_high ? charger_pkg::PM_FULL :
                    usb_pm_q + charger_pkg::PM_REDUCE_STEP;
    end
  end

  // current command
  wire usb_low_current_level_mode = src_usb_q & ~sel_high;
  wire [9:0] cc_pm = src_adp_q ? therm_pm_q : usb_pm_q;
  wire [9:0] pre_pm = usb_low_current_level_mode ? charger_pkg::PM_PRECON_USB_LOW_CURRENT_LEVEL :
                      charger_pkg::PM_PRECON;
  wire [9:0] pm_d = phase_q == charger_pkg::PH_PRECON ? pre_pm :
                    (phase_q == charger_pkg::PH_FAST ||
                     phase_q == charger_pkg::PH_CV) ? cc_pm : 10'h000;
  wire [10:0] ma_d = src_adp_q ? adp_ma_q :
                     sel_high ? usb_high_current_level_ma_q : usb_low_current_level_ma_q;
  wire [9:0] term_d = usb_low_current_level_mode ? charger_pkg::PM_TERM_USB_LOW_CURRENT_LEVEL :
                      charger_pkg::PM_TERM;

  // events: set wins over a clear in the same cycle
  logic [3:0] evt_set;
  always_comb begin
    evt_set = 4'h0;
    evt_set[charger_pkg::EVT_SUSPEND] =
        phase_q != charger_pkg::PH_SLEEP && !src_ok;
    evt_set[charger_pkg::EVT_RESUME] =
        phase_q == charger_pkg::PH_SLEEP && src_ok;
    evt_set[charger_pkg::EVT_THERM] = therm_enter;
    evt_set[charger_pkg::EVT_DONE] =
        phase_q == charger_pkg::PH_CV && phase_d == charger_pkg::PH_DONE;
  end
  wire [3:0] evt_clr = wr_clr ? wdata_q[3:0] : 4'h0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) evt_stat_q <= 4'h0;
    else evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
  end

  // outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      adapter_present_n_out <= 1'b0;
      adapter_present_n_oe_n <= 1'b1;
      charge_permille <= 10'h000;
      term_permille <= charger_pkg::PM_TERM;
      fast_charge_current <= charger_pkg::ADP_MA_RST;
      usb_high_current_level <= 1'b0;
      irq <= 1'b0;
    end else begin
      adapter_present_n_out <= 1'b0;
      adapter_present_n_oe_n <= ~adp_det;
      charge_permille <= pm_d;
      term_permille <= term_d;
      fast_charge_current <= ma_d;
      usb_high_current_level <= sel_high;
      irq <= |(((evt_stat_q & ~evt_clr) | evt_set) & evt_en_q);
    end
  end
  assign src_adp = src_adp_q;
  assign src_usb = src_usb_q;
  assign phase = phase_q;

  // read channel
  wire [31:0] state_word = {16'h0000, therm_pm_q[9:2], therm_q, src_usb_q,
                            src_adp_q, usb_sag, sel_high, phase_q};
  wire [7:0] rd_ofs = {s_axi_araddr[7:2], 2'b00};
  wire rd_ok = rd_ofs <= charger_pkg::EVT_EN_OFS &&
               rd_ofs != charger_pkg::EVT_CLR_OFS;
  wire [31:0] rd_mux =
      rd_ofs == charger_pkg::ADP_LEVEL_OFS ? {21'h0, adp_ma_q} :
      rd_ofs == charger_pkg::USB_HIGH_CURRENT_LEVEL_LEVEL_OFS ? {21'h0, usb_high_current_level_ma_q} :
      rd_ofs == charger_pkg::USB_LOW_CURRENT_LEVEL_LEVEL_OFS ? {21'h0, usb_low_current_level_ma_q} :
      rd_ofs == charger_pkg::STATE_OFS ? state_word :
      rd_ofs == charger_pkg::EVT_STAT_OFS ? {28'h0, evt_stat_q} :
      rd_ofs == charger_pkg::EVT_EN_OFS ? {28'h0, evt_en_q} : 32'h0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= charger_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? charger_pkg::RESP_OKAY :
                     charger_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = ~s_axi_rvalid & ~sys_rst;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wake;
    phase_q == charger_pkg::PH_SLEEP && src_ok;
  endsequence
  sequence s_reassess;
    phase_q == charger_pkg::PH_ASSESS ##1 phase_q != charger_pkg::PH_SLEEP;
  endsequence
  property p_adp_first;
    use_adp |=> src_adp_q && !src_usb_q;
  endproperty
  a_adp_first: assert property (p_adp_first)
    else $error("adapter not chosen");
  property p_flag;
    adp_det |-> ##1 !adapter_present_n_oe_n && !adapter_present_n_out;
  endproperty
  a_flag: assert property (p_flag)
    else $error("presence pin not pulled");
  property p_therm_start;
    $rose(therm_q) |-> therm_pm_q == charger_pkg::PM_THERM_START;
  endproperty
  a_therm_start: assert property (p_therm_start)
    else $error("thermal start level wrong");
  property p_therm_step;
    therm_q && therm_tick && !hot && !therm_top && src_adp_q && charging
      && phase_d == phase_q |=> therm_pm_q == $past(therm_up);
  endproperty
  a_therm_step: assert property (p_therm_step)
    else $error("thermal step missing");
  property p_timer_restart;
    therm_enter |=> therm_cnt_q == '0;
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("thermal timebase not restarted");
  property p_suspend;
    !src_ok |=> phase_q == charger_pkg::PH_SLEEP ##1 charge_permille == 0;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("no sleep on lost supply");
  property p_resume;
    s_wake |=> s_reassess or (phase_q == charger_pkg::PH_SLEEP);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume skipped assessment");
  property p_usb_src;
    use_usb |=> src_usb_q && !src_adp_q;
  endproperty
  a_usb_src: assert property (p_usb_src)
    else $error("usb not chosen");
  property p_reduce;
    src_usb_q && red_tick && usb_sag && !red_low && use_usb
      |=> usb_pm_q == $past(usb_pm_q) - charger_pkg::PM_REDUCE_STEP;
  endproperty
  a_reduce: assert property (p_reduce)
    else $error("usb reduction step missing");
  property p_precon;
    phase_q == charger_pkg::PH_PRECON |=> charge_permille == $past(pre_pm);
  endproperty
  a_precon: assert property (p_precon)
    else $error("precondition current wrong");
  property p_term;
    phase_q == charger_pkg::PH_CV && cur_term && src_ok && !src_change
      |=> phase_q == charger_pkg::PH_DONE;
  endproperty
  a_term: assert property (p_term)
    else $error("no termination");
endmodule : charger_ctrl

// file: src/charger_pkg.sv
// constants, types and register map of the charger source and phase control
// assumes a 50 MHz sys_clk and a 32-bit AXI4-Lite register bus
package charger_pkg;
  localparam int CLK_HZ = 50_000_000;
  // thermal re-evaluation interval, seconds
  localparam int THERM_PERIOD_S = 3;
  localparam int THERM_CYC = THERM_PERIOD_S * CLK_HZ;
  // usb reduction step interval, microseconds
  localparam int REDUCE_PERIOD_US = 100;
  localparam int REDUCE_CYC = REDUCE_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W = 28;

  // current fractions of the programmed level, in per mille
  localparam logic [9:0] PM_FULL = 10'h3E8;
  localparam logic [9:0] PM_THERM_START = 10'h1B8;
  localparam logic [9:0] PM_THERM_STEP = 10'h014;
  localparam logic [9:0] PM_PRECON = 10'h064;
  localparam logic [9:0] PM_PRECON_USB_LOW_CURRENT_LEVEL = 10'h1F4;
  localparam logic [9:0] PM_TERM = 10'h04B;
  localparam logic [9:0] PM_TERM_USB_LOW_CURRENT_LEVEL = 10'h15E;
  localparam logic [9:0] PM_REDUCE_STEP = 10'h00A;
  localparam logic [9:0] PM_REDUCE_MIN = 10'h000;

  // programmed levels, mA
  localparam logic [10:0] MA_USB_MIN = 11'h032;
  localparam logic [10:0] MA_USB_MAX = 11'h1F4;
  localparam logic [10:0] MA_ADP_MAX = 11'h5DC;
  localparam logic [10:0] ADP_MA_RST = 11'h1F4;
  localparam logic [10:0] USB_HIGH_CURRENT_LEVEL_MA_RST = 11'h1F4;
  localparam logic [10:0] USB_LOW_CURRENT_LEVEL_MA_RST = 11'h064;

  // register byte offsets
  localparam logic [7:0] ADP_LEVEL_OFS = 8'h00;
  localparam logic [7:0] USB_HIGH_CURRENT_LEVEL_LEVEL_OFS = 8'h04;
  localparam logic [7:0] USB_LOW_CURRENT_LEVEL_LEVEL_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  localparam logic [7:0] EVT_STAT_OFS = 8'h10;
  localparam logic [7:0] EVT_CLR_OFS = 8'h14;
  localparam logic [7:0] EVT_EN_OFS = 8'h18;

  // event bits
  localparam int EVT_W = 4;
  localparam int EVT_SUSPEND = 0;
  localparam int EVT_RESUME = 1;
  localparam int EVT_THERM = 2;
  localparam int EVT_DONE = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_SLEEP, PH_ASSESS, PH_PRECON, PH_FAST, PH_CV, PH_DONE
  } phase_t;
endpackage : charger_pkg

// file: sim/supply_pins_model.sv
// far side: adapter and usb supplies seen through their comparators
// assumes bench controls change just after sys_clk rising edges
module supply_pins_model (
  input wire logic adp_on,
  input wire logic adp_ok,
  input wire logic usb_on,
  input wire logic usb_ok,
  input wire logic sag,
  input wire logic sel_drv,
  input wire logic sel_val,
  output logic adapter_supply_input,
  output logic adp_above_undervoltage_lockout,
  output logic adp_above_bat,
  output logic usb_above_undervoltage_lockout,
  output logic reduction_threshold_input,
  output logic usb_level_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // an absent supply also fails its level comparators
  assign adapter_supply_input = adp_on;
  assign adp_above_undervoltage_lockout = adp_on & adp_ok;
  assign adp_above_bat = adp_on & adp_ok;
  assign usb_above_undervoltage_lockout = usb_on & usb_ok;
  assign reduction_threshold_input = usb_on & sag;
  // undriven select reads low through the pull-down
  assign usb_level_select = sel_drv ? sel_val : 1'h0;
endmodule : supply_pins_model

// file: sim/charger_ctrl_tb.sv
// self-checking bench: axi4-lite tasks and supply/pin scenarios
// assumes short thermal and reduction counts set at the instance
module charger_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 40;
  localparam int RC = 8;
  localparam logic [1:0] OK = charger_pkg::RESP_OKAY;
  localparam logic [1:0] ER = charger_pkg::RESP_SLVERR;
  logic sys_clk, sys_rst = 1'h1;
  logic adp_on = 1'h0, adp_ok = 1'h1, usb_on = 1'h0, usb_ok = 1'h1;
  logic sag = 1'h0, sel_drv = 1'h0, sel_val = 1'h0, enable = 1'h0;
  logic die_hot = 1'h0, bat_above_min = 1'h1, bat_at_reg = 1'h0;
  logic bat_below_rch = 1'h0, cur_below_term = 1'h0;
  wire logic adapter_supply_input, adp_above_undervoltage_lockout, adp_above_bat;
  wire logic usb_above_undervoltage_lockout, reduction_threshold_input, usb_level_select;
  logic adapter_present_n_out, adapter_present_n_oe_n, src_adp, src_usb;
  logic usb_high_current_level, irq;
  charger_pkg::phase_t phase;
  logic [9:0] charge_permille, term_permille;
  logic [10:0] fast_charge_current;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0, samples_checked = 0, n, k;

  supply_pins_model supply_pins_model_inst (.adp_on, .adp_ok, .usb_on,
    .usb_ok, .sag, .sel_drv, .sel_val, .adapter_supply_input,
    .adp_above_undervoltage_lockout, .adp_above_bat, .usb_above_undervoltage_lockout,
    .reduction_threshold_input, .usb_level_select);
  charger_ctrl #(.THERM_CYC(TC), .REDUCE_CYC(RC)) charger_ctrl_inst (
    .sys_clk, .sys_rst, .adapter_supply_input, .adp_above_undervoltage_lockout,
    .adp_above_bat, .usb_above_undervoltage_lockout, .reduction_threshold_input,
    .usb_level_select, .enable, .die_hot, .bat_above_min, .bat_at_reg,
    .bat_below_rch, .cur_below_term, .adapter_present_n_out,
    .adapter_present_n_oe_n, .src_adp, .src_usb, .usb_high_current_level,
    .phase, .charge_permille, .term_permille, .fast_charge_current, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(int c);
    repeat (c) @(negedge sys_clk);
  endtask : cyc

  task automatic ph(logic [2:0] p, logic [9:0] c);
    chk("phase", p, phase);
    chk("permille", c, charge_permille);
  endtask : ph

  // handshakes are judged at the falling edge, settled before the rise
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int i;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    i = 0;
    do begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      i++;
    end while (!tb && i < 50);
    s_axi_bready <= 1'h0;
    chk("bvalid", 1'h1, tb);
    chk("bresp", er, r);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    logic ta, tv;
    logic [1:0] r;
    logic [31:0] d;
    int i;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    i = 0;
    do begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tv = s_axi_rvalid;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'h0;
      i++;
    end while (!tv && i < 50);
    s_axi_rready <= 1'h0;
    chk("rvalid", 1'h1, tv);
    chk("rresp", er, r);
    if (er === OK) chk("rdata", e, d);
  endtask : rd

  // counts cycles until the commanded current moves
  task automatic nxt(output int c);
    logic [9:0] v;
    v = charge_permille;
    c = 0;
    while (charge_permille === v && c < 2000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : nxt

  task automatic ramp_to(logic [9:0] t);
    int m;
    for (int j = 0; j < 60 && charge_permille !== t; j++)
      nxt(m);
    chk("ramp", t, charge_permille);
  endtask : ramp_to

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd(8'h00, 32'h1F4, OK);
    rd(8'h04, 32'h1F4, OK);
    rd(8'h08, 32'h064, OK);
    rd(8'h1C, 32'h0, ER);
    rd(8'h14, 32'h0, ER);
    wr(8'h20, 32'h1, ER);
    wr(8'h00, 32'h7D0, OK);
    rd(8'h00, 32'h5DC, OK);
    // partial strobe on a level register must leave it untouched
    s_axi_wstrb <= 4'h1;
    wr(8'h00, 32'h064, OK);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 32'h5DC, OK);
    wr(8'h04, 32'h258, OK);
    rd(8'h04, 32'h1F4, OK);
    wr(8'h08, 32'h00A, OK);
    rd(8'h08, 32'h032, OK);
    wr(8'h08, 32'h064, OK);
    wr(8'h18, 32'h4, OK);
    rd(8'h18, 32'h4, OK);
    // both supplies up: adapter must win
    adp_on <= 1'h1;
    usb_on <= 1'h1;
    sel_drv <= 1'h1;
    sel_val <= 1'h1;
    enable <= 1'h1;
    cyc(8);
    chk("src_adp", 1'h1, src_adp);
    chk("src_usb", 1'h0, src_usb);
    chk("present_oe_n", 1'h0, adapter_present_n_oe_n);
    chk("present_out", 1'h0, adapter_present_n_out);
    chk("level", 32'h5DC, fast_charge_current);
    ph(charger_pkg::PH_FAST, charger_pkg::PM_FULL);
    chk("term", charger_pkg::PM_TERM, term_permille);
    wr(8'h14, 32'hF, OK);
    die_hot <= 1'h1;
    cyc(8);
    chk("therm", charger_pkg::PM_THERM_START, charge_permille);
    @(posedge sys_clk);
    die_hot <= 1'h0;
    nxt(n);
    chk("step", charger_pkg::PM_THERM_START + charger_pkg::PM_THERM_STEP,
      charge_permille);
    nxt(n);
    chk("interval", TC, n);
    ramp_to(charger_pkg::PM_FULL);
    chk("irq", 1'h1, irq);
    rd(8'h10, 32'h4, OK);
    wr(8'h18, 32'h0, OK);
    cyc(2);
    chk("irq_masked", 1'h0, irq);
    wr(8'h18, 32'h4, OK);
    cyc(2);
    chk("irq_unmasked", 1'h1, irq);
    wr(8'h14, 32'h4, OK);
    cyc(2);
    chk("irq_cleared", 1'h0, irq);
    rd(8'h10, 32'h0, OK);
    // adapter lockout with no usb behind it
    usb_on <= 1'h0;
    adp_ok <= 1'h0;
    cyc(8);
    ph(charger_pkg::PH_SLEEP, 10'h000);
    rd(8'h10, 32'h1, OK);
    bat_above_min <= 1'h0;
    adp_ok <= 1'h1;
    cyc(8);
    ph(charger_pkg::PH_PRECON, charger_pkg::PM_PRECON);
    @(posedge sys_clk);
    // adapter gone: usb takes over, then sags
    adp_on <= 1'h0;
    usb_on <= 1'h1;
    bat_above_min <= 1'h1;
    cyc(8);
    chk("src_usb", 1'h1, src_usb);
    chk("present_oe_n", 1'h1, adapter_present_n_oe_n);
    chk("level", 32'h1F4, fast_charge_current);
    chk("sel", 1'h1, usb_high_current_level);
    ph(charger_pkg::PH_FAST, charger_pkg::PM_FULL);
    @(posedge sys_clk);
    sag <= 1'h1;
    cyc(3 * RC + 4);
    chk("reduced", 1'h1, charge_permille < charger_pkg::PM_FULL);
    k = charge_permille;
    @(posedge sys_clk);
    sel_drv <= 1'h0;
    cyc(2 * RC);
    chk("sel", 1'h0, usb_high_current_level);
    chk("level", 32'h064, fast_charge_current);
    // sixteen edges hold exactly two reduction ticks
    chk("reduced_low", k - 2 * charger_pkg::PM_REDUCE_STEP,
      charge_permille);
    @(posedge sys_clk);
    sag <= 1'h0;
    ramp_to(charger_pkg::PM_FULL);
    @(posedge sys_clk);
    usb_ok <= 1'h0;
    bat_above_min <= 1'h0;
    cyc(8);
    ph(charger_pkg::PH_SLEEP, 10'h000);
    @(posedge sys_clk);
    usb_ok <= 1'h1;
    cyc(8);
    ph(charger_pkg::PH_PRECON, charger_pkg::PM_PRECON_USB_LOW_CURRENT_LEVEL);
    @(posedge sys_clk);
    enable <= 1'h0;
    bat_above_min <= 1'h1;
    bat_at_reg <= 1'h1;
    cyc(8);
    ph(charger_pkg::PH_SLEEP, 10'h000);
    @(posedge sys_clk);
    enable <= 1'h1;
    cyc(8);
    chk("phase", charger_pkg::PH_CV, phase);
    chk("term", charger_pkg::PM_TERM_USB_LOW_CURRENT_LEVEL, term_permille);
    @(posedge sys_clk);
    cur_below_term <= 1'h1;
    cyc(8);
    chk("phase", charger_pkg::PH_DONE, phase);
    @(posedge sys_clk);
    cur_below_term <= 1'h0;
    bat_at_reg <= 1'h0;
    bat_below_rch <= 1'h1;
    cyc(8);
    chk("phase", charger_pkg::PH_FAST, phase);
    // state word: full thermal level, usb source, low level, fast phase
    rd(8'h0C, 32'h0000_FA43, OK);
    give_verdict();
  end
endmodule : charger_ctrl_tb
